/* logic/gesl_pkg.sv */
// Purpose: shared constants of the grabber event source logic
// Assumes: one device module, one clock domain, APB register access
// Notes:   source numbers double as the identifier stored in the event queue
package gesl_pkg;

  // source population and widths
  localparam int NUM_SRC  = 45;
  localparam int SRC_W    = 6;
  localparam int CAUSE_W  = 6;
  localparam int QDEPTH   = 16;
  localparam int QPTR_W   = 4;
  localparam int NUM_MOD  = 1;   // device modules, hence camera_illum_controller instances

  // source numbers: data stream group
  localparam int SRC_FRAME_START = 0;
  localparam int SRC_FRAME_END   = 1;
  localparam int SRC_SCAN_START  = 2;
  localparam int SRC_SCAN_END    = 3;
  localparam int SRC_FRAME_REJ   = 4;
  localparam int SRC_SCAN_REJ    = 5;
  // source numbers: toolbox group
  localparam int SRC_LINE_IN     = 6;   // 8 line input tools
  localparam int SRC_DECODER     = 14;  // decoder1, decoder1 direction, decoder2, direction
  localparam int SRC_DIVIDER     = 18;  // 2 dividers
  localparam int SRC_MULDIV      = 20;  // 2 multiplier/dividers
  localparam int SRC_DELAY       = 22;  // tool1 out1, tool1 out2, tool2 out1, tool2 out2
  localparam int SRC_USER        = 26;  // 4 user events
  localparam int SRC_EVIN        = 30;  // 2 event inputs
  // source numbers: host interface connections A..D
  localparam int SRC_CRC         = 32;
  // source numbers: camera_illum_controller
  localparam int SRC_TRIG_RISE   = 36;
  localparam int SRC_TRIG_FALL   = 37;
  localparam int SRC_STROBE_RISE = 38;
  localparam int SRC_STROBE_FALL = 39;
  localparam int SRC_CYCLE_OK    = 40;
  localparam int SRC_TRIG_DISC   = 41;
  localparam int SRC_TRIG_PEND   = 42;
  localparam int SRC_TRIG_ACK    = 43;
  localparam int SRC_TRIG_RESEND = 44;

  // cause bitfield positions
  localparam int SCAN_START_CAUSE_LSB = 1;  // bits 3:1
  localparam int SCAN_END_CAUSE_LSB   = 1;  // bits 5:1

  // time stamp prescaler
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_IN_NS      = 1000;
  localparam int TICKS_PER_US  = US_IN_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICKS_PER_US - 1);

  // context word selectors
  localparam logic [1:0] CTX_CAUSE = 2'h0;
  localparam logic [1:0] CTX_IO    = 2'h1;
  localparam logic [1:0] CTX_COUNT = 2'h2;
  localparam logic [1:0] CTX_ZERO  = 2'h3;
  localparam logic [5:0] CTX_SEL_RESET = 6'h24;  // word0 cause, word1 io, word2 count

  // register byte offsets
  localparam logic [11:0] OFS_ENABLE_LO = 12'h000;
  localparam logic [11:0] OFS_ENABLE_HI = 12'h004;
  localparam logic [11:0] OFS_CTX_SEL   = 12'h008;
  localparam logic [11:0] OFS_CNT_CLR   = 12'h00c;
  localparam logic [11:0] OFS_Q_STATUS  = 12'h010;
  localparam logic [11:0] OFS_Q_POP     = 12'h014;
  localparam logic [11:0] OFS_Q_ID      = 12'h018;
  localparam logic [11:0] OFS_Q_TS      = 12'h01c;
  localparam logic [11:0] OFS_Q_CTX0    = 12'h020;
  localparam logic [11:0] OFS_Q_CTX1    = 12'h024;
  localparam logic [11:0] OFS_Q_CTX2    = 12'h028;
  localparam logic [11:0] OFS_COUNTER   = 12'h100;  // one word per source
  localparam logic [12:0] ENABLE_HI_MASK = 13'h1fff;

endpackage : gesl_pkg

/* logic/gesl_event_source.sv */
// Purpose: event detection, per-source counting and event queue of the grabber
// Assumes: event inputs are one-cycle pulses, trigger and strobe are levels
// Notes:   APB slave, pready follows ce, read data is taken one cycle early
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module gesl_event_source (
  // clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // firmware variant strap and io line state
  input  wire logic                    line_scan_variant,
  input  wire logic [31:0]             io_lines,
  // data stream
  input  wire logic                    pix_wr,
  input  wire logic                    pix_first,
  input  wire logic                    pix_last,
  input  wire logic                    image_drop,
  input  wire logic [1:0]              drop_cause,
  input  wire logic [3:1]              scan_start_cause,
  input  wire logic [5:1]              scan_end_cause,
  // toolbox tool outputs
  input  wire logic [7:0]              line_in_evt,
  input  wire logic [1:0]              quadrature_decoder_evt,
  input  wire logic [1:0]              decoder_direction_evt,
  input  wire logic [1:0]              divider_evt,
  input  wire logic [1:0]              muldiv_evt,
  input  wire logic [3:0]              delay_evt,
  input  wire logic [3:0]              user_evt,
  input  wire logic [1:0]              evin_evt,
  // host interface connections A..D
  input  wire logic [3:0]              crc_error,
  // camera_illum_controller
  input  wire logic                    camera_trigger,
  input  wire logic                    strobe,
  input  wire logic                    cycle_permitted,
  input  wire logic                    trigger_discarded,
  input  wire logic [3:0]              discard_cause,
  input  wire logic                    trigger_pending,
  input  wire logic [1:0]              pending_cause,
  input  wire logic                    trigger_ack,
  input  wire logic                    trigger_resend,
  // queue status
  output logic                         queue_not_empty
);
  import gesl_pkg::*;

  logic                    line_scan_reg;
  logic                    strap_done_reg;
  logic                    trig_prev_reg;
  logic                    strobe_prev_reg;
  logic [NUM_SRC-1:0]      evt;
  logic [CAUSE_W-1:0]      cause_vec [NUM_SRC];
  logic [31:0]             cnt_reg   [NUM_SRC];
  logic [31:0]             cnt_next  [NUM_SRC];
  logic [NUM_SRC-1:0]      enable_reg;
  logic [5:0]              ctx_sel_reg;
  logic [7:0]              tick_reg;
  logic [31:0]             usec_reg;
  logic [NUM_SRC-1:0]      pend_reg;
  logic [31:0]             hold_ts   [NUM_SRC];
  logic [31:0]             hold_ctx  [NUM_SRC][3];
  logic [SRC_W-1:0]        q_id      [QDEPTH];
  logic [31:0]             q_ts      [QDEPTH];
  logic [31:0]             q_ctx     [QDEPTH][3];
  logic [QPTR_W:0]         wr_ptr_reg;
  logic [QPTR_W:0]         rd_ptr_reg;
  logic [QPTR_W:0]         q_count;
  logic                    q_full;
  logic                    drain;
  logic [SRC_W-1:0]        drain_id;
  logic                    data_ok_reg;
  logic                    xfer;
  logic                    wr_xfer;
  logic                    addr_ok;
  logic [31:0]             rd_mux;
  logic [11:0]             cnt_ofs;
  logic [SRC_W-1:0]        cnt_idx;
  logic                    cnt_hit;
  logic                    clr_all;
  logic [QPTR_W-1:0]       head;

  // context word chosen by a two-bit selector
  function automatic logic [31:0] ctx_pick(input logic [1:0] sel,
                                           input logic [CAUSE_W-1:0] cause,
                                           input logic [31:0] io,
                                           input logic [31:0] cnt);
    logic [31:0] w;
    w = 32'h0;
    unique case (sel)
      CTX_CAUSE: w = {{(32-CAUSE_W){1'b0}}, cause};
      CTX_IO:    w = io;
      CTX_COUNT: w = cnt;
      CTX_ZERO:  w = 32'h0;
    endcase
    return w;
  endfunction : ctx_pick

  // variant strap caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_scan_reg  <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (ce && !strap_done_reg) begin
      line_scan_reg  <= line_scan_variant;
      strap_done_reg <= 1'b1;
    end
  end

  // previous levels for trigger and strobe edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg   <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end else if (ce) begin
      trig_prev_reg   <= camera_trigger;
      strobe_prev_reg <= strobe;
    end
  end

  // event vector and cause bitfields; one controller set per module
  always_comb begin
    evt = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      cause_vec[i] = '0;
    end
    if (strap_done_reg) begin
      evt[SRC_FRAME_START] = !line_scan_reg && pix_wr && pix_first;
      evt[SRC_FRAME_END]   = !line_scan_reg && pix_wr && pix_last;
      evt[SRC_SCAN_START]  = line_scan_reg && pix_wr && pix_first;
      evt[SRC_SCAN_END]    = line_scan_reg && pix_wr && pix_last;
      evt[SRC_FRAME_REJ]   = !line_scan_reg && image_drop;
      evt[SRC_SCAN_REJ]    = line_scan_reg && image_drop;
    end
    evt[SRC_LINE_IN +: 8]    = line_in_evt;
    evt[SRC_DECODER]         = quadrature_decoder_evt[0];
    evt[SRC_DECODER + 1]     = decoder_direction_evt[0];
    evt[SRC_DECODER + 2]     = quadrature_decoder_evt[1];
    evt[SRC_DECODER + 3]     = decoder_direction_evt[1];
    evt[SRC_DIVIDER +: 2]    = divider_evt;
    evt[SRC_MULDIV +: 2]     = muldiv_evt;
    evt[SRC_DELAY +: 4]      = delay_evt;
    evt[SRC_USER +: 4]       = user_evt;
    evt[SRC_EVIN +: 2]       = evin_evt;
    evt[SRC_CRC +: 4]        = crc_error;
    evt[SRC_TRIG_RISE]       = camera_trigger && !trig_prev_reg;
    evt[SRC_TRIG_FALL]       = !camera_trigger && trig_prev_reg;
    evt[SRC_STROBE_RISE]     = strobe && !strobe_prev_reg;
    evt[SRC_STROBE_FALL]     = !strobe && strobe_prev_reg;
    evt[SRC_CYCLE_OK]        = cycle_permitted;
    evt[SRC_TRIG_DISC]       = trigger_discarded;
    evt[SRC_TRIG_PEND]       = trigger_pending;
    evt[SRC_TRIG_ACK]        = trigger_ack;
    evt[SRC_TRIG_RESEND]     = trigger_resend;
    cause_vec[SRC_TRIG_DISC] = {2'b00, discard_cause};
    cause_vec[SRC_TRIG_PEND] = {4'b0000, pending_cause};
    cause_vec[SRC_SCAN_START][SCAN_START_CAUSE_LSB +: 3] = scan_start_cause;
    cause_vec[SRC_SCAN_END][SCAN_END_CAUSE_LSB +: 5]     = scan_end_cause;
    cause_vec[SRC_FRAME_REJ] = {4'b0000, drop_cause};
    cause_vec[SRC_SCAN_REJ]  = {4'b0000, drop_cause};
  end

  // microsecond time stamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 8'h0;
      usec_reg <= 32'h0;
    end else if (ce) begin
      if (tick_reg == TICK_LAST) begin
        tick_reg <= 8'h0;
        usec_reg <= usec_reg + 32'h1;
      end else begin
        tick_reg <= tick_reg + 8'h1;
      end
    end
  end

  // apb decode; ce low stretches the access
  assign xfer    = psel && penable && pready;
  assign wr_xfer = xfer && pwrite;
  assign pready  = psel && penable && data_ok_reg && ce;
  assign pslverr = pready && !addr_ok;
  assign cnt_ofs = paddr - OFS_COUNTER;
  assign cnt_idx = cnt_ofs[SRC_W+1:2];
  assign cnt_hit = (paddr >= OFS_COUNTER) && (paddr[1:0] == 2'b00)
                   && (cnt_ofs[11:2] < 10'(NUM_SRC));
  assign clr_all = wr_xfer && (paddr == OFS_CNT_CLR) && pwdata[0];
  assign head    = rd_ptr_reg[QPTR_W-1:0];

  // counters: clear with a same-cycle event leaves a count of one
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      if (clr_all || (wr_xfer && cnt_hit && cnt_idx == SRC_W'(i))) begin
        cnt_next[i] = {31'h0, evt[i]};
      end else begin
        cnt_next[i] = cnt_reg[i] + {31'h0, evt[i]};
      end
    end
  end

  // counter storage, counting regardless of notification enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        cnt_reg[i] <= 32'h0;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // notification enables and context selectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg  <= '0;
      ctx_sel_reg <= CTX_SEL_RESET;
    end else if (ce && wr_xfer) begin
      if (paddr == OFS_ENABLE_LO) begin
        enable_reg[31:0] <= pwdata;
      end
      if (paddr == OFS_ENABLE_HI) begin
        enable_reg[NUM_SRC-1:32] <= pwdata[NUM_SRC-33:0];
      end
      if (paddr == OFS_CTX_SEL) begin
        ctx_sel_reg <= pwdata[5:0];
      end
    end
  end

  // lowest pending source goes to the queue while room remains
  always_comb begin
    drain_id = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        drain_id = SRC_W'(i);
      end
    end
  end
  assign q_count = wr_ptr_reg - rd_ptr_reg;
  assign q_full  = q_count[QPTR_W];
  assign drain   = (|pend_reg) && !q_full;

  // per-source hold of a notified event; a new event wins over the drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        hold_ts[i] <= 32'h0;
        for (int k = 0; k < 3; k++) begin
          hold_ctx[i][k] <= 32'h0;
        end
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (evt[i] && enable_reg[i] && !(pend_reg[i] && !(drain && drain_id == SRC_W'(i)))) begin
          pend_reg[i] <= 1'b1;
          hold_ts[i]  <= usec_reg;
          for (int k = 0; k < 3; k++) begin
            hold_ctx[i][k] <= ctx_pick(ctx_sel_reg[2*k +: 2], cause_vec[i],
                                       io_lines, cnt_next[i]);
          end
        end else if (drain && drain_id == SRC_W'(i)) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // event queue storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      for (int j = 0; j < QDEPTH; j++) begin
        q_id[j] <= '0;
        q_ts[j] <= 32'h0;
        for (int k = 0; k < 3; k++) begin
          q_ctx[j][k] <= 32'h0;
        end
      end
    end else if (ce) begin
      if (drain) begin
        q_id[wr_ptr_reg[QPTR_W-1:0]] <= drain_id;
        q_ts[wr_ptr_reg[QPTR_W-1:0]] <= hold_ts[drain_id];
        for (int k = 0; k < 3; k++) begin
          q_ctx[wr_ptr_reg[QPTR_W-1:0]][k] <= hold_ctx[drain_id][k];
        end
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (wr_xfer && paddr == OFS_Q_POP && q_count != '0) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
  assign queue_not_empty = (q_count != '0);

  // read mux and address check
  always_comb begin
    rd_mux  = 32'h0;
    addr_ok = 1'b1;
    if (cnt_hit) begin
      rd_mux = cnt_reg[cnt_idx];
    end else begin
      unique case (paddr)
        OFS_ENABLE_LO: rd_mux = enable_reg[31:0];
        OFS_ENABLE_HI: rd_mux = {19'h0, enable_reg[NUM_SRC-1:32]};
        OFS_CTX_SEL:   rd_mux = {26'h0, ctx_sel_reg};
        OFS_CNT_CLR:   rd_mux = 32'h0;
        OFS_Q_STATUS:  rd_mux = {line_scan_reg, 15'h0, 11'h0, q_count};
        OFS_Q_POP:     rd_mux = 32'h0;
        OFS_Q_ID:      rd_mux = {26'h0, q_id[head]};
        OFS_Q_TS:      rd_mux = q_ts[head];
        OFS_Q_CTX0:    rd_mux = q_ctx[head][0];
        OFS_Q_CTX1:    rd_mux = q_ctx[head][1];
        OFS_Q_CTX2:    rd_mux = q_ctx[head][2];
        default:       addr_ok = 1'b0;
      endcase
    end
  end

  // read data register and one-cycle data-ready phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0;
      data_ok_reg <= 1'b0;
    end else if (ce) begin
      if (psel && !xfer) begin
        prdata      <= rd_mux;
        data_ok_reg <= 1'b1;
      end else begin
        data_ok_reg <= 1'b0;
      end
    end
  end

endmodule : gesl_event_source

/* tb/gesl_event_source_sva.sv */
// Purpose: concurrent checks on the apb slave and queue flag of the event source block
// Assumes: one clock domain, asynchronous active low reset
// Notes:   sees only the top ports; attached by bind from the testbench top
`timescale 1ns/10ps
module gesl_event_source_sva (
  // clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // queue status
  input wire logic        queue_not_empty
);
  import gesl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed pop write and unmapped address window
  wire logic pop_w = pready && pwrite && (paddr == OFS_Q_POP);
  wire logic hole  = (paddr >= 12'h02c && paddr < OFS_COUNTER) || (paddr >= 12'h1b4);
  sequence s_setup;  psel && !penable && ce; endsequence
  sequence s_access; psel && penable && ce; endsequence
  property p_zero_wait; s_setup ##1 s_access |-> pready; endproperty
  property p_ready_cause; pready |-> psel && penable && ce; endproperty
  property p_err_in_access; pslverr |-> pready; endproperty
  property p_hole_err; pready && hole |-> pslverr; endproperty
  property p_map_ok; pready && paddr[1:0] == 2'h0 && !hole |-> !pslverr; endproperty
  property p_err_data; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_qne_hold; queue_not_empty && !pop_w |=> queue_not_empty; endproperty
  property p_pop_falls; $fell(queue_not_empty) |-> $past(pop_w); endproperty
  property p_empty_count;
    pready && !pwrite && paddr == OFS_Q_STATUS && !queue_not_empty |-> prdata[4:0] == 5'h0;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready late after setup");
  a_ready_cause: assert property (p_ready_cause) else $error("pready outside access");
  a_err_in_access: assert property (p_err_in_access) else $error("pslverr without pready");
  a_hole_err: assert property (p_hole_err) else $error("unmapped address accepted");
  a_map_ok: assert property (p_map_ok) else $error("mapped address refused");
  a_err_data: assert property (p_err_data) else $error("refused read returned data");
  a_qne_hold: assert property (p_qne_hold) else $error("queue lost entries");
  a_pop_falls: assert property (p_pop_falls) else $error("queue emptied without pop");
  a_empty_count: assert property (p_empty_count) else $error("count nonzero when empty");
endmodule : gesl_event_source_sva

/* tb/test_gesl_event_source.sv */
// Purpose: self-checking bench of the event source block over apb
// Assumes: 250 MHz clock, xorshift stimulus, reads scored from a queue of notes
// Notes:   drives the event inputs from one source vector, trigger and strobe from separate levels, both firmware variants
`timescale 1ns/10ps
module test_gesl_event_source;
  import gesl_pkg::*;
  // apb and control
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, queue_not_empty;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, io = 32'h0, cz = 32'h0, r;
  logic [31:0] seed = 32'h9d5d09cc;
  // event stimulus: one bit per source number, levels for trigger and strobe
  logic [44:0] ev = '0;
  logic        trig = 1'b0, strb = 1'b0, lsv = 1'b0;
  logic [32:0] expq[$];
  int          n_mismatch = 0, compares = 0, cyc = 0, i;
  // clock
  always #2 pclk = ~pclk;
  gesl_event_source gesl_event_source_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_scan_variant(lsv), .io_lines(io),
    .pix_wr(|ev[3:0]), .pix_first(ev[0] | ev[2]), .pix_last(ev[1] | ev[3]),
    .image_drop(ev[4] | ev[5]), .drop_cause(cz[1:0]), .scan_start_cause(cz[3:1]),
    .scan_end_cause(cz[5:1]), .line_in_evt(ev[13:6]), .quadrature_decoder_evt({ev[16], ev[14]}),
    .decoder_direction_evt({ev[17], ev[15]}), .divider_evt(ev[19:18]), .muldiv_evt(ev[21:20]),
    .delay_evt(ev[25:22]), .user_evt(ev[29:26]), .evin_evt(ev[31:30]), .crc_error(ev[35:32]),
    .camera_trigger(trig), .strobe(strb), .cycle_permitted(ev[40]),
    .trigger_discarded(ev[41]), .discard_cause(cz[3:0]), .trigger_pending(ev[42]),
    .pending_cause(cz[1:0]), .trigger_ack(ev[43]), .trigger_resend(ev[44]),
    .queue_not_empty(queue_not_empty));
  // xorshift source of stimulus values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // compare tasks, one per kind of result
  task automatic cmp_word(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // apb master: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: pready ends this wait, else the bench timeout does
    while (!pready) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  // one-cycle pulse of the chosen sources, edges for trigger and strobe
  task automatic pulse(input logic [44:0] m);
    @(posedge pclk);
    ev <= m & ~(45'hf << 36);
    if (m[36] | m[37]) trig <= m[36];
    if (m[38] | m[39]) strb <= m[38];
    @(posedge pclk);
    ev <= '0;
  endtask : pulse
  task automatic do_reset(input logic v);
    presetn <= 1'b0;
    lsv <= v;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  // read monitor and timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite && expq.size() > 0)
      cmp_word("read data", expq.pop_front(), {pslverr, prdata});
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    do_reset(1'b0);
    rd(OFS_ENABLE_LO, 32'h0);
    rd(OFS_ENABLE_HI, 32'h0);
    fork
      begin
        @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join_none
    rd(OFS_CTX_SEL, 32'(CTX_SEL_RESET));
    rd(OFS_Q_STATUS, 32'h0);
    apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
    r = rnd();
    wr(OFS_ENABLE_HI, r);
    rd(OFS_ENABLE_HI, 32'(r[12:0]));
    wr(OFS_ENABLE_HI, 32'h0);
    io <= rnd();
    cz <= rnd();
    // every source except 2, 3 and 5 once with notification off: counted, never queued
    for (i = 0; i < NUM_SRC; i++) if (!(i inside {2, 3, 5})) pulse(45'h1 << i);
    repeat (3) @(posedge pclk);
    cmp_flag("queue flag", 1'b0, queue_not_empty);
    for (i = 0; i < NUM_SRC; i++) rd(OFS_COUNTER + 12'(4 * i), 32'(!(i inside {2, 3, 5})));
    wr(OFS_COUNTER + 12'h018, 32'h0);
    rd(OFS_COUNTER + 12'h018, 32'h0);
    rd(OFS_COUNTER + 12'h01c, 32'h1);
    wr(OFS_CNT_CLR, 32'h1);
    rd(OFS_COUNTER + 12'h010, 32'h0);
    // three simultaneous notified events, drained lowest source first
    wr(OFS_ENABLE_LO, 32'h1 << 26);
    wr(OFS_ENABLE_HI, 32'h3 << 9);
    cz <= rnd();
    pulse((45'h1 << 26) | (45'h3 << 41));
    repeat (4) @(posedge pclk);
    cmp_flag("queue flag", 1'b1, queue_not_empty);
    rd(OFS_Q_STATUS, 32'h3);
    rd(OFS_Q_ID, SRC_USER);
    rd(OFS_Q_CTX1, io);
    rd(OFS_Q_CTX2, 32'h1);
    wr(OFS_Q_POP, 32'h0);
    rd(OFS_Q_ID, SRC_TRIG_DISC);
    rd(OFS_Q_CTX0, 32'(cz[3:0]));
    wr(OFS_Q_POP, 32'h0);
    rd(OFS_Q_ID, SRC_TRIG_PEND);
    rd(OFS_Q_CTX0, 32'(cz[1:0]));
    wr(OFS_Q_POP, 32'h0);
    rd(OFS_Q_STATUS, 32'h0);
    // line-scan variant after a second reset
    do_reset(1'b1);
    rd(OFS_Q_STATUS, 32'h80000000);
    wr(OFS_ENABLE_LO, 32'h2c);
    // word0 and word1 forced to zero, word2 carries the cause
    wr(OFS_CTX_SEL, 32'h0f);
    rd(OFS_CTX_SEL, 32'h0f);
    cz <= rnd();
    for (i = 2; i < 6; i++) if (i != 4) pulse(45'h1 << i);
    for (i = 0; i < 6; i++) rd(OFS_COUNTER + 12'(4 * i), 32'(i inside {2, 3, 5}));
    rd(OFS_Q_CTX0, 32'h0);
    rd(OFS_Q_CTX2, 32'({cz[3:1], 1'b0}));
    wr(OFS_Q_POP, 32'h0);
    rd(OFS_Q_ID, SRC_SCAN_END);
    rd(OFS_Q_CTX2, 32'({cz[5:1], 1'b0}));
    wr(OFS_Q_POP, 32'h0);
    rd(OFS_Q_CTX2, 32'(cz[1:0]));
    // let the monitor score the last read before closing
    repeat (2) @(posedge pclk);
    cmp_word("reads answered", 33'h0, 33'(expq.size()));
    give_verdict();
  end
endmodule : test_gesl_event_source
bind gesl_event_source gesl_event_source_sva gesl_event_source_sva_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .queue_not_empty(queue_not_empty));
